// file: bel_pkg.sv
// Summary of operation
// [RULE_01] Bit 30 set when we drive bus-init
// [RULE_02] Bit 31 set when bus-init observed
// [RULE_03] Bit 34 set on controller/bus data parity
// [RULE_04] Bit 36 set on response-status parity error
// [RULE_05] Response parity checked against external parity pin
// [RULE_06] Bit 37 reflects address parity error detected
// [RULE_07] Bit 38 set on retirement timeout
// [RULE_08] Timeout is carry out of 23-bit counter
// [RULE_09] Counter clears on retire, exception, reset, timeout
// [RULE_10] Prescaler: 8-bit timer, bus clock over 128
// [RULE_11] Bus clock is 1:2, 1:3 or 1:4 core
// [RULE_12] Each prescaler carry advances counter by one
// [RULE_13] Bit 38 set keeps logged status frozen
// [RULE_14] Bit 42 set on hard-error response, freezes
// [RULE_15] Bit 43 set on internal error, freezes
// [RULE_16] Bits 63:57 carry architectural validity indicators
// [RULE_17] Bits 27:25 encode 001/010/011 error type
// [RULE_18] Reserved bits read zero, ignore writes
`default_nettype none
package bel_pkg;
	localparam logic [11:0] STAT_LO_OFS  = 12'h000;
	localparam logic [11:0] STAT_HI_OFS  = 12'h004;
	localparam logic [11:0] MASK_LO_OFS  = 12'h008;
	localparam logic [11:0] MASK_HI_OFS  = 12'h00c;
	localparam logic [11:0] CTRL_OFS     = 12'h010;
	localparam logic [11:0] TOCNT_OFS    = 12'h014;
	localparam int BIT_MCE_DRV    = 28;
	localparam int BIT_MCE_OBS    = 29;
	localparam int BIT_BUS_INIT_SIGNAL_DRV  = 30;
	localparam int BIT_BUS_INIT_SIGNAL_OBS  = 31;
	localparam int BIT_DATA_PAR   = 34;
	localparam int BIT_RESP_PAR   = 36;
	localparam int BIT_ADDR_PAR   = 37;
	localparam int BIT_TIMEOUT    = 38;
	localparam int BIT_HARD_ERR   = 42;
	localparam int BIT_INT_ERR    = 43;
	localparam int ETYPE_LSB      = 25;
	localparam logic [2:0] ETYPE_ADDR_PAR  = 3'h1;
	localparam logic [2:0] ETYPE_HARD_ERR  = 3'h2;
	localparam logic [2:0] ETYPE_RESP_PAR  = 3'h3;
	// Writable-to-clear event bits; reserved and validity bits stay zero
	localparam logic [63:0] EVENT_MASK     = 64'h0000_0c74_f000_0000;
	localparam logic [63:0] STATUS_RESET   = 64'h0000_0000_0000_0000;
	localparam int PRESC_WIDTH    = 8;
	localparam int TOCNT_WIDTH    = 23;
	localparam int PRESC_DIV      = 128;
	localparam logic [1:0] RATIO_RESET    = 2'h0;
endpackage : bel_pkg
`default_nettype wire

// file: bel_logger.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bel_logger #(
	parameter int TOCNT_W = bel_pkg::TOCNT_WIDTH,
	parameter int PRESC_W = bel_pkg::PRESC_WIDTH
) (
	// Clock and reset
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Bus and core events
	input  wire logic        MCE_DRIVEN_I,
	input  wire logic        MCE_OBSERVED_I,
	input  wire logic        BUS_INIT_DRIVEN_I,
	input  wire logic        BUS_INIT_OBSERVED_I,
	input  wire logic        DATA_PARITY_ERR_I,
	input  wire logic        RESPONSE_VALID_I,
	input  wire logic [2:0]  RESPONSE_STATUS_PINS_I,
	input  wire logic        RESPONSE_PARITY_PIN_I,
	input  wire logic        ADDR_PARITY_ERR_I,
	input  wire logic        HARD_ERROR_RESP_I,
	input  wire logic        INTERNAL_ERROR_PIN_I,
	input  wire logic        UOP_RETIRED_I,
	input  wire logic        CORE_EXCEPTION_I,
	// Architectural fields supplied from outside this block
	input  wire logic [6:0]  VALIDITY_I,
	input  wire logic [15:0] ERROR_CODE_I,
	input  wire logic [5:0]  REQ_TYPE_I,
	// Outputs
	output logic             TIMEOUT_BUS_INIT_O,
	output logic             IRQ_O
);
	import bel_pkg::*;

	logic [63:0]        status_q;
	logic [63:0]        mask_q;
	logic [1:0]         ratio_q;
	logic [1:0]         ratio_cnt_q;
	logic               bus_tick;
	logic [6:0]         div_q;
	logic [PRESC_W-1:0] presc_q;
	logic [TOCNT_W-1:0] tocnt_q;
	logic               presc_carry;
	logic               to_carry;
	logic               timeout_q;
	logic               resp_par_err;
	logic               frozen;
	logic [63:0]        set_vec;
	logic [63:0]        clr_vec;
	logic               wr_en;
	logic               rd_en;
	logic               addr_ok;

	// Bus clock tick from core clock: ratio 0->1:2, 1->1:3, 2/3->1:4 [RULE_11]
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			ratio_cnt_q <= 2'h0;
		end else if (bus_tick) begin
			ratio_cnt_q <= 2'h0;
		end else begin
			ratio_cnt_q <= ratio_cnt_q + 2'h1;
		end
	end

	always_comb begin
		case (ratio_q)
			2'h0:    bus_tick = (ratio_cnt_q == 2'h1);
			2'h1:    bus_tick = (ratio_cnt_q == 2'h2);
			default: bus_tick = (ratio_cnt_q == 2'h3);
		endcase
	end

	// Divide bus clock by 128, then 8-bit timer counts those ticks [RULE_10]
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			div_q   <= 7'h0;
			presc_q <= '0;
		end else if (bus_tick) begin
			div_q <= div_q + 7'h1;
			if (div_q == 7'h7f) begin
				presc_q <= presc_q + PRESC_W'(1);
			end
		end
	end

	assign presc_carry = bus_tick && (div_q == 7'h7f) && (&presc_q);
	assign to_carry    = presc_carry && (&tocnt_q); // [RULE_08]

	// Clear on retire, exception, reset or our own timeout bus-init [RULE_09]
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			tocnt_q <= '0;
		end else if (UOP_RETIRED_I || CORE_EXCEPTION_I || timeout_q) begin
			tocnt_q <= '0;
		end else if (presc_carry) begin
			tocnt_q <= tocnt_q + TOCNT_W'(1); // [RULE_12]
		end
	end

	// Timeout raises bus-init for one cycle
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= to_carry;
		end
	end

	assign TIMEOUT_BUS_INIT_O = timeout_q;

	// Even parity over status pins and parity pin expected from the agent [RULE_05]
	assign resp_par_err = RESPONSE_VALID_I && (^{RESPONSE_STATUS_PINS_I, RESPONSE_PARITY_PIN_I});

	// Sticky error bits freeze the error type and request fields (27:19) [RULE_13] [RULE_14] [RULE_15]
	assign frozen = status_q[BIT_TIMEOUT] || status_q[BIT_HARD_ERR] || status_q[BIT_INT_ERR];

	always_comb begin
		set_vec = '0;
		set_vec[BIT_MCE_DRV]   = MCE_DRIVEN_I;
		set_vec[BIT_MCE_OBS]   = MCE_OBSERVED_I;
		set_vec[BIT_BUS_INIT_SIGNAL_DRV] = BUS_INIT_DRIVEN_I || timeout_q; // [RULE_01]
		set_vec[BIT_BUS_INIT_SIGNAL_OBS] = BUS_INIT_OBSERVED_I; // [RULE_02]
		set_vec[BIT_DATA_PAR]  = DATA_PARITY_ERR_I; // [RULE_03]
		set_vec[BIT_RESP_PAR]  = resp_par_err; // [RULE_04]
		set_vec[BIT_ADDR_PAR]  = ADDR_PARITY_ERR_I; // [RULE_06]
		set_vec[BIT_TIMEOUT]   = to_carry; // [RULE_07]
		set_vec[BIT_HARD_ERR]  = HARD_ERROR_RESP_I; // [RULE_14]
		set_vec[BIT_INT_ERR]   = INTERNAL_ERROR_PIN_I; // [RULE_15]
	end

	// APB decode, zero wait states
	assign addr_ok = (PADDR_I == STAT_LO_OFS) || (PADDR_I == STAT_HI_OFS) ||
	                 (PADDR_I == MASK_LO_OFS) || (PADDR_I == MASK_HI_OFS) ||
	                 (PADDR_I == CTRL_OFS) || (PADDR_I == TOCNT_OFS);
	assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
	assign rd_en     = PSEL_I && PENABLE_I && !PWRITE_I;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

	always_comb begin
		clr_vec = '0;
		if (wr_en && PADDR_I == STAT_LO_OFS) begin
			clr_vec[31:0] = PWDATA_I;
		end
		if (wr_en && PADDR_I == STAT_HI_OFS) begin
			clr_vec[63:32] = PWDATA_I;
		end
		clr_vec = clr_vec & EVENT_MASK; // [RULE_18]
	end

	// Write one to clear; a new event wins over a clear in the same cycle
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			status_q <= STATUS_RESET;
		end else begin
			status_q <= (status_q & ~clr_vec) | (set_vec & EVENT_MASK);
			if (!frozen && (ADDR_PARITY_ERR_I || HARD_ERROR_RESP_I || resp_par_err)) begin
				// Error type field, priority address > hard > response [RULE_17]
				if (ADDR_PARITY_ERR_I) begin
					status_q[ETYPE_LSB +: 3] <= ETYPE_ADDR_PAR;
				end else if (HARD_ERROR_RESP_I) begin
					status_q[ETYPE_LSB +: 3] <= ETYPE_HARD_ERR;
				end else begin
					status_q[ETYPE_LSB +: 3] <= ETYPE_RESP_PAR;
				end
				status_q[24:19] <= REQ_TYPE_I;
			end else if (clr_vec[BIT_TIMEOUT] || clr_vec[BIT_HARD_ERR] || clr_vec[BIT_INT_ERR] ||
			             (clr_vec[63:0] != 64'h0 && !frozen)) begin
				status_q[27:19] <= (wr_en && PADDR_I == STAT_LO_OFS) ? 9'h0 : status_q[27:19];
			end
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			mask_q  <= 64'h0;
			ratio_q <= RATIO_RESET;
		end else if (wr_en) begin
			if (PADDR_I == MASK_LO_OFS) begin
				mask_q[31:0] <= PWDATA_I & EVENT_MASK[31:0];
			end
			if (PADDR_I == MASK_HI_OFS) begin
				mask_q[63:32] <= PWDATA_I & EVENT_MASK[63:32];
			end
			if (PADDR_I == CTRL_OFS) begin
				ratio_q <= PWDATA_I[1:0];
			end
		end
	end

	assign IRQ_O = |(status_q & mask_q & EVENT_MASK);

	// Low code and validity fields are passed through from outside [RULE_16]
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			PRDATA_O <= 32'h0;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			case (PADDR_I)
				STAT_LO_OFS: PRDATA_O <= {status_q[31:16], ERROR_CODE_I};
				STAT_HI_OFS: PRDATA_O <= {VALIDITY_I, status_q[56:32]};
				MASK_LO_OFS: PRDATA_O <= mask_q[31:0];
				MASK_HI_OFS: PRDATA_O <= mask_q[63:32];
				CTRL_OFS:    PRDATA_O <= {30'h0, ratio_q};
				TOCNT_OFS:   PRDATA_O <= {{(32-TOCNT_W){1'b0}}, tocnt_q};
				default:     PRDATA_O <= 32'h0;
			endcase
		end
	end

	logic unused_rd;
	assign unused_rd = rd_en;
endmodule : bel_logger
`default_nettype wire

// file: bel_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bel_properties import bel_pkg::*; #(
	parameter int TOCNT_W = 23,
	parameter int PRESC_W = 8
) (
	// Clock and reset
	input wire logic        CLOCK_I,
	input wire logic        RST_I,
	// Register bus
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PSLVERR_O,
	// Core events, timeout and validity field
	input wire logic        UOP_RETIRED_I,
	input wire logic        CORE_EXCEPTION_I,
	input wire logic        TIMEOUT_BUS_INIT_O,
	input wire logic [6:0]  VALIDITY_I
);
	localparam int STEP = 128 * (1 << PRESC_W);
	localparam int N = 1 << TOCNT_W;
	int         cnt_q, m;
	logic [1:0] rat_q;
	logic       seen_q;
	wire logic  acc = PSEL_I && PENABLE_I;
	wire logic  rd_hi = acc && !PWRITE_I && PADDR_I == STAT_HI_OFS;
	wire logic  rd_lo = acc && !PWRITE_I && PADDR_I == STAT_LO_OFS;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);
	assign m = rat_q == 2'h0 ? 2 : rat_q == 2'h1 ? 3 : 4;
	// Prescaler runs free, so the first step after a clear may be short
	always_ff @(posedge CLOCK_I or posedge RST_I)
		if (RST_I) cnt_q <= 0;
		else cnt_q <= (UOP_RETIRED_I || CORE_EXCEPTION_I || TIMEOUT_BUS_INIT_O) ? 0 : cnt_q + 1;
	always_ff @(posedge CLOCK_I or posedge RST_I)
		if (RST_I) rat_q <= 2'h0;
		else if (acc && PWRITE_I && PADDR_I == CTRL_OFS) rat_q <= PWDATA_I[1:0];
	always_ff @(posedge CLOCK_I or posedge RST_I)
		if (RST_I) seen_q <= 1'h0;
		// Clear first: the flag was set on the edge that raised the pulse, so a clear then wins
		else if (acc && PWRITE_I && PADDR_I == STAT_HI_OFS && PWDATA_I[6]) seen_q <= 1'h0;
		else if (TIMEOUT_BUS_INIT_O) seen_q <= 1'h1;
	sequence s_fire; TIMEOUT_BUS_INIT_O ##1 !TIMEOUT_BUS_INIT_O; endsequence
	property p_rsvd; rd_hi |-> (PRDATA_O & 32'h01ff_f38b) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_valid; rd_hi |-> PRDATA_O[31:25] == $past(VALIDITY_I); endproperty
	a_valid: assert property (p_valid) else $error("validity field wrong");
	property p_flag; rd_hi && $past(seen_q) |-> PRDATA_O[6]; endproperty
	a_flag: assert property (p_flag) else $error("timeout flag lost");
	property p_type; rd_lo |-> PRDATA_O[27:25] <= 3'h3; endproperty
	a_type: assert property (p_type) else $error("bad error type");
	property p_pulse; TIMEOUT_BUS_INIT_O |-> s_fire; endproperty
	a_pulse: assert property (p_pulse) else $error("timeout pulse too long");
	property p_early; TIMEOUT_BUS_INIT_O |-> cnt_q >= (N - 1) * m * STEP; endproperty
	a_early: assert property (p_early) else $error("timeout too early");
	property p_late; cnt_q <= (N * m + 4) * STEP + 8; endproperty
	a_late: assert property (p_late) else $error("timeout too late");
	property p_unm; acc && !PWRITE_I && PADDR_I > TOCNT_OFS |-> PSLVERR_O && PRDATA_O == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not refused");
endmodule : bel_properties
bind bel_logger bel_properties #(
	.TOCNT_W(TOCNT_W),
	.PRESC_W(PRESC_W)
) u_props (
	.CLOCK_I(CLOCK_I),
	.RST_I(RST_I),
	.PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I),
	.PRDATA_O(PRDATA_O),
	.PSLVERR_O(PSLVERR_O),
	.UOP_RETIRED_I(UOP_RETIRED_I),
	.CORE_EXCEPTION_I(CORE_EXCEPTION_I),
	.TIMEOUT_BUS_INIT_O(TIMEOUT_BUS_INIT_O),
	.VALIDITY_I(VALIDITY_I)
);
`default_nettype wire

// file: bel_agent.sv
`timescale 1ns/1ps
`default_nettype none
module bel_agent (
	// Control
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       send_i,
	input  wire logic       bad_i,
	// Response pins
	output logic            valid_o,
	output logic            par_o,
	output logic      [2:0] rs_o
);
	// Even parity; bad_i breaks it on purpose. Idle pins toggle, not hold
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i) {valid_o, par_o, rs_o} <= 5'h0;
		else if (send_i) {valid_o, par_o, rs_o} <= {1'h1, ^3'h5 ^ bad_i, 3'h5};
		else {valid_o, par_o, rs_o} <= {1'h0, ~par_o, ~rs_o};
endmodule : bel_agent
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bel_pkg::*;
	logic             clk, rst, psel, pen, pwr, bad, uop, exc, se;
	logic      [11:0] pa, ad;
	logic      [31:0] pwd, r, m;
	logic      [8:0]  ev;
	wire logic        rdy, slv, rv, rp, tmo, irq;
	wire logic [2:0]  rs;
	wire logic [31:0] prd;
	int               errors, total_checks, n;
	localparam int BP [8] = '{28, 29, 30, 31, 34, 37, 42, 43};
	bel_logger #(.TOCNT_W(2), .PRESC_W(2)) bel_logger_inst (
		.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
		.PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(slv), .MCE_DRIVEN_I(ev[0]),
		.MCE_OBSERVED_I(ev[1]), .BUS_INIT_DRIVEN_I(ev[2]), .BUS_INIT_OBSERVED_I(ev[3]),
		.DATA_PARITY_ERR_I(ev[4]), .ADDR_PARITY_ERR_I(ev[5]), .HARD_ERROR_RESP_I(ev[6]),
		.INTERNAL_ERROR_PIN_I(ev[7]), .RESPONSE_VALID_I(rv), .RESPONSE_STATUS_PINS_I(rs),
		.RESPONSE_PARITY_PIN_I(rp), .UOP_RETIRED_I(uop), .CORE_EXCEPTION_I(exc), .VALIDITY_I(7'h55),
		.ERROR_CODE_I(16'ha5c3), .REQ_TYPE_I(6'h2a), .TIMEOUT_BUS_INIT_O(tmo), .IRQ_O(irq));
	bel_agent bel_agent_inst (.clk_i(clk), .rst_i(rst), .send_i(ev[8]), .bad_i(bad), .valid_o(rv),
		.par_o(rp), .rs_o(rs));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic conclude();
		if (errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk) pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		r = prd;
		se = slv;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask : xfer
	task automatic pulse(input int i);
		ev[i] <= 1'h1;
		@(posedge clk) ev <= 9'h0;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic lo(input logic [2:0] t);
		xfer(1'h0, STAT_LO_OFS, 32'h0);
		chk(r & 32'h0fff_ffff, {4'h0, t, 6'h2a, 3'h0, 16'ha5c3});
	endtask : lo
	initial begin
		#700us;
		errors++;
		conclude();
	end
	initial begin
		{psel, pen, pwr, pa, pwd, ev, bad, uop, exc} = '0;
		errors = 0;
		total_checks = 0;
		rst = 1'h1;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			ad = BP[i] > 31 ? STAT_HI_OFS : STAT_LO_OFS;
			m = 32'h1 << (BP[i] % 32);
			pulse(i);
			xfer(1'h0, ad, 32'h0);
			chk(r & (BP[i] > 31 ? 32'h0c74 : 32'hf000_0000), m);
			chk(irq, 1'h0);
			xfer(1'h1, ad + 12'h8, m);
			chk(irq, 1'h1);
			xfer(1'h1, ad, m);
			chk(irq, 1'h0);
			xfer(1'h1, ad + 12'h8, 32'h0);
		end
		pulse(6);
		lo(3'h2);
		pulse(5);
		lo(3'h2);
		xfer(1'h1, STAT_HI_OFS, 32'h0c74);
		pulse(5);
		lo(3'h1);
		pulse(7);
		bad <= 1'h1;
		pulse(8);
		lo(3'h1);
		xfer(1'h0, STAT_HI_OFS, 32'h0);
		chk(r & 32'h0c74, 32'h0830);
		xfer(1'h1, STAT_HI_OFS, 32'h0c74);
		pulse(8);
		lo(3'h3);
		xfer(1'h1, STAT_HI_OFS, 32'h0c74);
		bad <= 1'h0;
		pulse(8);
		xfer(1'h0, STAT_HI_OFS, 32'h0);
		chk(r & 32'h0c74, 32'h0);
		xfer(1'h0, 12'h020, 32'h0);
		chk({31'h0, se}, 32'h1);
		chk(r, 32'h0);
		xfer(1'h1, MASK_HI_OFS, 32'hffff_ffff);
		xfer(1'h0, MASK_HI_OFS, 32'h0);
		chk(r, 32'h0000_0c74);
		xfer(1'h1, MASK_LO_OFS, 32'hffff_ffff);
		xfer(1'h0, MASK_LO_OFS, 32'h0);
		chk(r, 32'hf000_0000);
		xfer(1'h1, MASK_HI_OFS, 32'h0);
		xfer(1'h1, MASK_LO_OFS, 32'h0);
		xfer(1'h0, STAT_HI_OFS, 32'h0);
		chk(r & 32'hfe00_0000, 32'haa00_0000);
		chk(r & 32'h01ff_f38b, 32'h0);
		// Ratio 3 decodes like ratio 2, so it is run as well
		for (int k = 0; k < 4; k++) begin
			xfer(1'h1, CTRL_OFS, k);
			xfer(1'h0, CTRL_OFS, 32'h0);
			chk(r & 32'h3, k);
			uop <= 1'h1;
			@(posedge clk) uop <= 1'h0;
			n = 0;
			while (tmo !== 1'h1 && n < 9000) begin
				@(posedge clk);
				n++;
			end
			chk(tmo, 1'h1);
			repeat (3) @(posedge clk);
			xfer(1'h0, STAT_HI_OFS, 32'h0);
			chk(r[6], 1'h1);
			xfer(1'h1, STAT_HI_OFS, 32'h40);
			xfer(1'h1, STAT_LO_OFS, 32'h4000_0000);
		end
		xfer(1'h1, CTRL_OFS, 32'h0);
		n = 0;
		// Same-source gaps exceed a period, so each clear source is needed
		for (int j = 0; j < 12000; j++) begin
			uop <= j % 6000 == 0;
			exc <= j % 6000 == 3000;
			@(posedge clk);
			n += tmo;
		end
		chk(n, 32'h0);
		conclude();
	end
endmodule : tb
`default_nettype wire
